/* core/timer_pkg.sv */
// constants for the timer prescaler, count pin and event flags.
// assumes APB with one aligned word per register.
package timer_pkg;

    // --------------------------------
    // register indices; byte address is four times the index
    // --------------------------------
    localparam logic [7:0]  SYNC_CTRL_IDX   = 8'h23;
    localparam logic [7:0]  EVENT_FLAGS_IDX = 8'h16;
    localparam logic [7:0]  IRQ_ENABLE_IDX  = 8'h6f;
    localparam logic [7:0]  CLOCK_SEL_IDX   = 8'h25;
    localparam logic [7:0]  WAVE_CTRL_IDX   = 8'h21;

    localparam int          ADDR_W          = 12;
    localparam logic [11:0] SYNC_CTRL_ADDR   = {2'h0, SYNC_CTRL_IDX,   2'h0};
    localparam logic [11:0] EVENT_FLAGS_ADDR = {2'h0, EVENT_FLAGS_IDX, 2'h0};
    localparam logic [11:0] IRQ_ENABLE_ADDR  = {2'h0, IRQ_ENABLE_IDX,  2'h0};
    localparam logic [11:0] CLOCK_SEL_ADDR   = {2'h0, CLOCK_SEL_IDX,   2'h0};
    localparam logic [11:0] WAVE_CTRL_ADDR   = {2'h0, WAVE_CTRL_IDX,   2'h0};

    // --------------------------------
    // field positions and reset values
    // --------------------------------
    localparam int          SYNC_MODE_BIT   = 7;
    localparam int          PRESC_RST_BIT   = 0;
    localparam int          CAPTURE_BIT     = 5;
    localparam int          COMPARE_B_BIT   = 2;
    localparam int          COMPARE_A_BIT   = 1;
    localparam int          OVERFLOW_BIT    = 0;
    localparam logic [7:0]  FLAG_MASK       = 8'h27;
    localparam int          FORCE_A_BIT     = 7;
    localparam int          FORCE_B_BIT     = 6;
    localparam int          CS_W            = 3;
    localparam int          WAVE_W          = 4;
    localparam logic [7:0]  SYNC_CTRL_RST   = 8'h00;
    localparam logic [7:0]  EVENT_FLAGS_RST = 8'h00;
    localparam logic [7:0]  IRQ_ENABLE_RST  = 8'h00;
    localparam logic [7:0]  CLOCK_SEL_RST   = 8'h00;
    localparam logic [3:0]  WAVE_RST        = 4'h0;

    // --------------------------------
    // clock select codes and prescaler taps
    // --------------------------------
    localparam logic [2:0]  CS_STOP         = 3'h0;
    localparam logic [2:0]  CS_DIV1         = 3'h1;
    localparam logic [2:0]  CS_DIV8         = 3'h2;
    localparam logic [2:0]  CS_DIV64        = 3'h3;
    localparam logic [2:0]  CS_DIV256       = 3'h4;
    localparam logic [2:0]  CS_DIV1024      = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL     = 3'h6;
    localparam logic [2:0]  CS_EXT_RISE     = 3'h7;
    localparam int          PRESC_W         = 10;
    localparam logic [9:0]  TAP_DIV8        = 10'h007;
    localparam logic [9:0]  TAP_DIV64       = 10'h03f;
    localparam logic [9:0]  TAP_DIV256      = 10'h0ff;
    localparam logic [9:0]  TAP_DIV1024     = 10'h3ff;
    localparam logic [9:0]  PRESC_RST       = 10'h000;

    // --------------------------------
    // waveform modes that matter to the flags
    // --------------------------------
    localparam logic [3:0]  WAVE_NORMAL     = 4'h0;
    localparam logic [3:0]  WAVE_CTC_CMPA   = 4'h4;
    localparam logic [3:0]  WAVE_CTC_CAPT   = 4'hc;
    localparam logic [3:0]  WAVE_PWM_CAPT_A = 4'h8;
    localparam logic [3:0]  WAVE_PWM_CAPT_B = 4'ha;
    localparam logic [3:0]  WAVE_FAST_CAPT  = 4'he;

endpackage

/* core/timer_prescaler_and_flags.sv */
// timer prescaler, count-pin edge detector and 16-bit timer flags.
// assumes APB on mclk and a counter core reporting its events.
//
// How it works
// RULE1 - overflow request needs enable, global, flag
// RULE2 - capture flag on capture or top
// RULE3 - capture flag cleared by vector or one
// RULE4 - compare B flag one tick after equal
// RULE5 - compare A flag one tick after equal
// RULE6 - forced compare strobes never set flags
// RULE7 - compare flags cleared by vector or one
// RULE8 - overflow flag set on counter overflow
// RULE9 - overflow flag cleared by vector or one
// RULE10 - software writes zero to unused flag bits
// RULE11 - select 1 undivided, others 8..1024 taps
// RULE12 - prescaler free running and shared
// RULE13 - count pin synchronised before edge detection
// RULE14 - select 7 rising, 6 falling edges
// RULE15 - pin edge reaches counter within cycles
// RULE16 - software switches input while pin steady
// RULE17 - external half period above one cycle
// RULE18 - external edges bypass the prescaler
// RULE19 - sync mode keeps prescaler reset bit
// RULE20 - clearing sync mode clears reset bit
// RULE21 - reset bit resets prescaler, self clears
// RULE22 - ten-bit prescaler with single-cycle taps
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps

module timer_prescaler_and_flags #(
    parameter int NUM_TIMERS = 2
) (
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    input  wire logic [timer_pkg::ADDR_W-1:0] paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [NUM_TIMERS-1:0]        external_count_pin,
    input  wire logic                         counter_overflow,
    input  wire logic                         compare_a_equal,
    input  wire logic                         compare_b_equal,
    input  wire logic                         capture_event,
    input  wire logic                         counter_at_top,
    input  wire logic                         global_irq_enable,
    input  wire logic                         ack_overflow,
    input  wire logic                         ack_compare_a,
    input  wire logic                         ack_compare_b,
    input  wire logic                         ack_capture,
    output logic      [NUM_TIMERS-1:0]        timer_tick,
    output logic      [3:0]                   waveform_mode_field,
    output logic                              force_compare_a,
    output logic                              force_compare_b,
    output logic                              prescaler_held,
    output logic                              irq_overflow,
    output logic                              irq_compare_a,
    output logic                              irq_compare_b,
    output logic                              irq_capture
);

    // --------------------------------
    // decode helpers
    // --------------------------------
    // true when the prescaler count sits on the last cycle of a tap
    function automatic logic tap_hit(
        input logic [timer_pkg::PRESC_W-1:0] cnt,
        input logic [2:0]                    sel
    );
        logic hit;
        hit = 1'b0;
        case (sel)
            timer_pkg::CS_DIV8:    hit = (cnt[2:0] == timer_pkg::TAP_DIV8[2:0]);
            timer_pkg::CS_DIV64:   hit = (cnt[5:0] == timer_pkg::TAP_DIV64[5:0]);
            timer_pkg::CS_DIV256:  hit = (cnt[7:0] == timer_pkg::TAP_DIV256[7:0]);
            timer_pkg::CS_DIV1024: hit = (cnt == timer_pkg::TAP_DIV1024);
            default:               hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic capture_is_top(input logic [3:0] mode);
        return (mode == timer_pkg::WAVE_PWM_CAPT_A) ||
               (mode == timer_pkg::WAVE_PWM_CAPT_B) ||
               (mode == timer_pkg::WAVE_CTC_CAPT)   ||
               (mode == timer_pkg::WAVE_FAST_CAPT);
    endfunction

    function automatic logic addr_is(
        input logic [timer_pkg::ADDR_W-1:0] a,
        input logic [timer_pkg::ADDR_W-1:0] reg_addr
    );
        return a == reg_addr;
    endfunction

    // --------------------------------
    // register state
    // --------------------------------
    logic                         sync_mode_q;
    logic                         sync_mode_d;
    logic                         presc_rst_q;
    logic                         presc_rst_d;
    logic [7:0]                   flags_q;
    logic [7:0]                   flags_d;
    logic [7:0]                   irq_en_q;
    logic [7:0]                   clk_sel_q;
    logic [3:0]                   wave_q;
    logic                         force_a_q;
    logic                         force_b_q;
    logic [timer_pkg::PRESC_W-1:0] presc_q;
    logic [31:0]                  prdata_q;
    logic [NUM_TIMERS-1:0]        tick_d;

    // --------------------------------
    // APB decode
    // --------------------------------
    wire setup_phase  = psel & ~penable;
    wire access_phase = psel & penable;
    wire hit_sync     = addr_is(paddr, timer_pkg::SYNC_CTRL_ADDR);
    wire hit_flags    = addr_is(paddr, timer_pkg::EVENT_FLAGS_ADDR);
    wire hit_irq_en   = addr_is(paddr, timer_pkg::IRQ_ENABLE_ADDR);
    wire hit_clk_sel  = addr_is(paddr, timer_pkg::CLOCK_SEL_ADDR);
    wire hit_wave     = addr_is(paddr, timer_pkg::WAVE_CTRL_ADDR);
    wire hit_any      = hit_sync | hit_flags | hit_irq_en |
                        hit_clk_sel | hit_wave;
    wire wr_en        = access_phase & pwrite & hit_any;
    wire wr_sync      = wr_en & hit_sync;
    wire wr_flags     = wr_en & hit_flags;
    wire wr_irq_en    = wr_en & hit_irq_en;
    wire wr_clk_sel   = wr_en & hit_clk_sel;
    wire wr_wave      = wr_en & hit_wave;

    // zero wait states: data is staged during the setup cycle
    assign pready  = 1'b1;
    assign pslverr = access_phase & ~hit_any;
    assign prdata  = prdata_q;

    wire [7:0] sync_view = {sync_mode_q, 6'h00, presc_rst_q};
    // forced compare bits are strobes and always read back as zero
    wire [7:0] wave_view = {4'h0, wave_q};
    wire [7:0] read_mux  = hit_sync    ? sync_view :
                           hit_flags   ? flags_q   :
                           hit_irq_en  ? irq_en_q  :
                           hit_clk_sel ? clk_sel_q :
                           hit_wave    ? wave_view : 8'h00;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata_q <= {24'h00_0000, read_mux};
        end
    end

    // --------------------------------
    // prescaler reset and synchronisation mode
    // --------------------------------
    always_comb begin
        sync_mode_d = sync_mode_q;
        presc_rst_d = presc_rst_q;
        if (wr_sync) begin
            sync_mode_d = pwdata[timer_pkg::SYNC_MODE_BIT];
            presc_rst_d = pwdata[timer_pkg::PRESC_RST_BIT];
            if (!pwdata[timer_pkg::SYNC_MODE_BIT]) begin
                presc_rst_d = 1'b0; // RULE20
            end
            // a plain write of one still resets the prescaler for a cycle
            if (pwdata[timer_pkg::PRESC_RST_BIT]) begin
                presc_rst_d = pwdata[timer_pkg::SYNC_MODE_BIT]; // RULE19
            end
        end else if (!sync_mode_q) begin
            presc_rst_d = 1'b0; // RULE21
        end
    end

    // the write pulse itself resets the counter even when the bit drops
    wire presc_clear = presc_rst_q |
                       (wr_sync & pwdata[timer_pkg::PRESC_RST_BIT]); // RULE21

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sync_mode_q <= timer_pkg::SYNC_CTRL_RST[timer_pkg::SYNC_MODE_BIT];
            presc_rst_q <= timer_pkg::SYNC_CTRL_RST[timer_pkg::PRESC_RST_BIT];
        end else begin
            sync_mode_q <= sync_mode_d;
            presc_rst_q <= presc_rst_d;
        end
    end

    assign prescaler_held = presc_rst_q;

    // --------------------------------
    // shared prescaler
    // --------------------------------
    // ignores clock select, so a first divided tick takes 1 to N cycles
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            presc_q <= timer_pkg::PRESC_RST;
        end else if (presc_clear) begin
            presc_q <= timer_pkg::PRESC_RST; // RULE21
        end else begin
            presc_q <= presc_q + 10'h001; // RULE12 RULE22
        end
    end

    // --------------------------------
    // control registers
    // --------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_en_q  <= timer_pkg::IRQ_ENABLE_RST;
            clk_sel_q <= timer_pkg::CLOCK_SEL_RST;
            wave_q    <= timer_pkg::WAVE_RST;
        end else begin
            if (wr_irq_en) begin
                irq_en_q <= pwdata[7:0] & timer_pkg::FLAG_MASK;
            end
            if (wr_clk_sel) begin
                clk_sel_q <= {2'h0, pwdata[5:0]};
            end
            if (wr_wave) begin
                wave_q <= pwdata[3:0];
            end
        end
    end

    // forced compares go to the counter core as one-cycle strobes only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            force_a_q <= 1'b0;
            force_b_q <= 1'b0;
        end else begin
            force_a_q <= wr_wave & pwdata[timer_pkg::FORCE_A_BIT];
            force_b_q <= wr_wave & pwdata[timer_pkg::FORCE_B_BIT];
        end
    end

    assign waveform_mode_field = wave_q;
    assign force_compare_a     = force_a_q;
    assign force_compare_b     = force_b_q;

    // --------------------------------
    // per-timer clock source: synchroniser, edge detector, tick select
    // --------------------------------
    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t = t + 1) begin : g_timer
            logic       pin_meta_q;
            logic       pin_sync_q;
            logic       pin_prev_q;
            wire  [2:0] sel = clk_sel_q[t*3 +: 3];

            // sampling assumes each pin half period exceeds one cycle
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    pin_meta_q <= 1'b0;
                    pin_sync_q <= 1'b0;
                    pin_prev_q <= 1'b0;
                end else begin
                    pin_meta_q <= external_count_pin[t]; // RULE13 RULE17
                    pin_sync_q <= pin_meta_q;
                    pin_prev_q <= pin_sync_q;
                end
            end

            wire rise_seen = pin_sync_q & ~pin_prev_q;
            wire fall_seen = ~pin_sync_q & pin_prev_q;
            wire ext_tick  = ((sel == timer_pkg::CS_EXT_RISE) & rise_seen) |
                             ((sel == timer_pkg::CS_EXT_FALL) & fall_seen);
            // internal sources halt while the prescaler is held
            wire int_tick  = ~presc_rst_q &
                             ((sel == timer_pkg::CS_DIV1) |
                              tap_hit(presc_q, sel)); // RULE11

            // external edges count one for one, never divided
            assign tick_d[t] = ext_tick | int_tick; // RULE14 RULE18
        end
    endgenerate

    // left unregistered so pin edge to counter update stays near 3 cycles
    assign timer_tick = tick_d; // RULE15

    // --------------------------------
    // 16-bit timer event flags
    // --------------------------------
    wire t16_tick = tick_d[NUM_TIMERS-1];

    // equal is sampled on the next tick, one tick late; forces ignored
    wire set_cmp_a = t16_tick & compare_a_equal; // RULE5 RULE6
    wire set_cmp_b = t16_tick & compare_b_equal; // RULE4 RULE6
    wire set_ovf   = counter_overflow; // RULE8
    wire set_cap   = capture_is_top(wave_q) ?
                     (t16_tick & counter_at_top) : capture_event; // RULE2

    wire [7:0] flag_set = {2'h0, set_cap, 2'h0,
                           set_cmp_b, set_cmp_a, set_ovf};
    // reserved positions are masked so stray ones do nothing
    wire [7:0] sw_clear = wr_flags ?
                          (pwdata[7:0] & timer_pkg::FLAG_MASK) : 8'h00; // RULE10
    wire [7:0] hw_clear = {2'h0, ack_capture, 2'h0,
                           ack_compare_b, ack_compare_a, ack_overflow};

    // an event in the clearing cycle wins over the clear
    assign flags_d = ((flags_q & ~(sw_clear | hw_clear)) | flag_set) &
                     timer_pkg::FLAG_MASK; // RULE3 RULE7 RULE9

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= timer_pkg::EVENT_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // --------------------------------
    // interrupt requests
    // --------------------------------
    wire [7:0] pending = flags_q & irq_en_q & {8{global_irq_enable}};

    assign irq_overflow  = pending[timer_pkg::OVERFLOW_BIT]; // RULE1
    assign irq_compare_a = pending[timer_pkg::COMPARE_A_BIT];
    assign irq_compare_b = pending[timer_pkg::COMPARE_B_BIT];
    assign irq_capture   = pending[timer_pkg::CAPTURE_BIT];

endmodule // timer_prescaler_and_flags

/* dv/tpf_props.sv */
// assertions on flag requests, prescaler hold and apb writes
// assumes bind onto the block; sees only its ports
`timescale 1ns/10ps
module tpf_props #(
    parameter int NUM_TIMERS = 2
) (
    input wire logic                  mclk,
    input wire logic                  rstn,
    input wire logic [11:0]           paddr,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           pwdata,
    input wire logic [NUM_TIMERS-1:0] timer_tick,
    input wire logic                  counter_overflow,
    input wire logic                  compare_a_equal,
    input wire logic                  ack_overflow,
    input wire logic                  global_irq_enable,
    input wire logic                  prescaler_held,
    input wire logic                  irq_overflow,
    input wire logic                  irq_compare_a
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire wr = psel && penable && pwrite;
    wire sync_wr = wr && paddr == timer_pkg::SYNC_CTRL_ADDR;
    wire en_wr = wr && paddr == timer_pkg::IRQ_ENABLE_ADDR;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    sequence stays_free;
        !prescaler_held ##1 !prescaler_held;
    endsequence
    chk_irq_global: assert property (
        irq_overflow |-> global_irq_enable)
        else $error("overflow request without global enable");
    chk_ovf_cause: assert property (
        $rose(irq_overflow) |-> $past(counter_overflow)
            || $rose(global_irq_enable) || $past(en_wr))
        else $error("overflow request without overflow");
    // a force write is no cause, so only enable writes or a global enable rise excuse a rise
    chk_cmpa_cause: assert property (
        $rose(irq_compare_a) |-> $past(compare_a_equal
            && timer_tick[NUM_TIMERS-1])
            || $rose(global_irq_enable) || $past(en_wr))
        else $error("compare a request without match tick");
    chk_ack_ovf: assert property (
        ack_overflow && !counter_overflow |=> !irq_overflow)
        else $error("overflow flag kept after vector");
    chk_presc_pulse: assert property (
        sync_wr && pwdata[7:0] == 8'h01 |=> stays_free)
        else $error("prescaler reset did not self clear");
    chk_sync_keep: assert property (
        sync_wr && pwdata[7:0] == 8'h81 |=> prescaler_held [*2])
        else $error("prescaler reset not kept in sync mode");
    chk_sync_clear: assert property (
        sync_wr && !pwdata[7] && !pwdata[0] |=> !prescaler_held)
        else $error("prescaler reset kept after sync mode off");
    chk_held_stops: assert property (
        prescaler_held ##1 prescaler_held |-> !timer_tick[0])
        else $error("internal tick while prescaler held");
endmodule // tpf_props

bind timer_prescaler_and_flags tpf_props #(.NUM_TIMERS(NUM_TIMERS))
    u_props (.mclk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .timer_tick, .counter_overflow, .compare_a_equal, .ack_overflow,
    .global_irq_enable, .prescaler_held, .irq_overflow, .irq_compare_a);

/* dv/ext_count_source.sv */
// model of the external clock source on the count pin
// assumes the bench stops it before any clock select change
`timescale 1ns/10ps
module ext_count_source (
    input  wire logic       mclk,
    input  wire logic       run,
    input  wire logic [7:0] half,
    output logic            pin
);
    logic [7:0] cnt_q = 8'h00;
    initial pin = 1'b0;
    // pin stands still while stopped; half must exceed one cycle
    always @(posedge mclk) begin
        if (run && cnt_q >= half - 8'h01) begin
            pin   <= ~pin;
            cnt_q <= 8'h00;
        end else if (run) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule // ext_count_source

/* dv/tb_timer_prescaler_and_flags.sv */
// self-checking bench for the timer prescaler and flag block
// assumes core sources, checker bind and the pin source model
`timescale 1ns/10ps
module tb_timer_prescaler_and_flags;
    logic        mclk = 1'b0;
    logic        rstn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  timer_tick;
    logic [3:0]  src = 4'h0;
    logic [3:0]  ack = 4'h0;
    logic [3:0]  irq;
    logic        counter_at_top = 1'b0;
    logic        global_irq_enable = 1'b0;
    logic        run = 1'b0;
    logic        pin;
    logic [31:0] rd;
    logic        er;
    int          n;
    int          error_cnt = 0;
    int          checks = 0;
    always #20 mclk = ~mclk;
    timer_prescaler_and_flags #(.NUM_TIMERS(2)) u_dut (
        .mclk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .external_count_pin({pin, pin}),
        .counter_overflow(src[0]), .compare_a_equal(src[1]),
        .compare_b_equal(src[2]), .capture_event(src[3]),
        .counter_at_top, .global_irq_enable, .ack_overflow(ack[0]),
        .ack_compare_a(ack[1]), .ack_compare_b(ack[2]),
        .ack_capture(ack[3]), .timer_tick, .waveform_mode_field(),
        .force_compare_a(), .force_compare_b(), .prescaler_held(),
        .irq_overflow(irq[0]), .irq_compare_a(irq[1]),
        .irq_compare_b(irq[2]), .irq_capture(irq[3]));
    ext_count_source u_src (.mclk, .run, .half(8'h03), .pin);
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [7:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // skips two cycles so a select change has settled in the ticks
    task automatic count(input int b, input int c);
        repeat (2) @(posedge mclk);
        n = 0;
        repeat (c) begin
            @(negedge mclk);
            if (timer_tick[b] === 1'b1) n++;
        end
    endtask
    task automatic pulse(input int i);
        src[i] <= 1'b1;
        @(posedge mclk);
        src[i] <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        apb(timer_pkg::SYNC_CTRL_ADDR, 1'b0, 8'h00);
        cmp(rd, {24'h0, timer_pkg::SYNC_CTRL_RST});
        apb(timer_pkg::EVENT_FLAGS_ADDR, 1'b0, 8'h00);
        cmp(rd, {24'h0, timer_pkg::EVENT_FLAGS_RST});
        apb(12'hffc, 1'b0, 8'h00);
        cmp({rd[30:0], er}, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_flags();
        int b[4] = '{0, 1, 2, 5};
        apb(timer_pkg::CLOCK_SEL_ADDR, 1'b1, 8'h08);
        apb(timer_pkg::IRQ_ENABLE_ADDR, 1'b1, timer_pkg::FLAG_MASK);
        global_irq_enable <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            pulse(i);
            @(negedge mclk);
            cmp(irq, 4'h1 << i);
            apb(timer_pkg::EVENT_FLAGS_ADDR, 1'b0, 8'h00);
            cmp(rd, 32'h1 << b[i]);
            apb(timer_pkg::EVENT_FLAGS_ADDR, 1'b1, 8'h01 << b[i]);
            @(negedge mclk);
            cmp(irq, 4'h0);
            pulse(i);
            ack[i] <= 1'b1;
            @(posedge mclk);
            ack[i] <= 1'b0;
            @(negedge mclk);
            cmp(irq, 4'h0);
        end
        pulse(0);
        global_irq_enable <= 1'b0;
        @(negedge mclk);
        cmp(irq, 4'h0);
        @(posedge mclk);
        global_irq_enable <= 1'b1;
        counter_at_top    <= 1'b1;
        @(posedge mclk);
        counter_at_top <= 1'b0;
        @(negedge mclk);
        cmp(irq, 4'h1);
        apb(timer_pkg::WAVE_CTRL_ADDR, 1'b1, {4'h0, timer_pkg::WAVE_CTC_CAPT});
        counter_at_top <= 1'b1;
        ack[0]         <= 1'b1;
        @(posedge mclk);
        counter_at_top <= 1'b0;
        ack[0]         <= 1'b0;
        ack[3]         <= 1'b1;
        @(negedge mclk);
        cmp(irq, 4'h8);
        @(posedge mclk);
        ack[3] <= 1'b0;
        @(negedge mclk);
        cmp(irq, 4'h0);
        $display("test flags done");
    endtask
    task automatic t_force();
        apb(timer_pkg::WAVE_CTRL_ADDR, 1'b1, 8'hc0);
        repeat (3) @(negedge mclk);
        cmp(irq, 4'h0);
        apb(timer_pkg::EVENT_FLAGS_ADDR, 1'b0, 8'h00);
        cmp(rd, 32'h0);
        $display("test force done");
    endtask
    task automatic t_presc();
        int dv[6] = '{0, 1, 8, 64, 256, 1024};
        for (int k = 0; k < 6; k++) begin
            apb(timer_pkg::CLOCK_SEL_ADDR, 1'b1, 8'(k));
            count(0, 2048);
            cmp(n, k == 0 ? 0 : 2048 / dv[k]);
        end
        apb(timer_pkg::CLOCK_SEL_ADDR, 1'b1, 8'h01);
        apb(timer_pkg::SYNC_CTRL_ADDR, 1'b1, 8'h81);
        count(0, 64);
        cmp(n, 0);
        apb(timer_pkg::SYNC_CTRL_ADDR, 1'b0, 8'h00);
        cmp(rd, 32'h81);
        apb(timer_pkg::SYNC_CTRL_ADDR, 1'b1, 8'h00);
        count(0, 64);
        cmp(n, 64);
        apb(timer_pkg::CLOCK_SEL_ADDR, 1'b1, 8'h02);
        apb(timer_pkg::SYNC_CTRL_ADDR, 1'b1, 8'h01);
        @(negedge mclk);
        n = 1;
        while (timer_tick[0] !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        cmp(n >= 1 && n <= 10, 1);
        apb(timer_pkg::SYNC_CTRL_ADDR, 1'b0, 8'h00);
        cmp(rd, 32'h0);
        $display("test prescaler done");
    endtask
    task automatic t_ext();
        logic [7:0] cs[3] = '{8'h38, 8'h30, 8'h38};
        for (int k = 0; k < 2; k++) begin
            apb(timer_pkg::CLOCK_SEL_ADDR, 1'b1, cs[k]);
            run <= 1'b1;
            fork
                count(1, 64);
                begin
                    repeat (47) @(posedge mclk);
                    run <= 1'b0;
                end
            join
            cmp(n, 8);
        end
        apb(timer_pkg::CLOCK_SEL_ADDR, 1'b1, cs[2]);
        run <= 1'b1;
        @(posedge pin);
        n = 0;
        while (timer_tick[1] !== 1'b1 && n < 9) begin
            @(negedge mclk);
            n++;
        end
        cmp(n, 3);
        @(posedge mclk);
        run <= 1'b0;
        $display("test external done");
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_flags();
        t_force();
        t_presc();
        t_ext();
        close_out();
    end
    // about four times the expected run length
    initial begin
        #2000000;
        error_cnt++;
        close_out();
    end
endmodule // tb_timer_prescaler_and_flags
